// File: verilog/rxs_status_regs.sv
// Register hub for per-port sensor status, parity and self-test counts.
// Assumes the I2C target decodes transactions into the byte access port.
// Register map; all but the port select belong to the selected port:
//   0x4c  port select, read and write, bits 1:0 pick the port
//   0x53  sensor_status_word_two, read only, loaded by the link
//   0x54  sensor_status_word_three, read only, loaded by the link
//   0x55  parity_error_count_high, read only
//   0x56  parity_error_count_low, a read restarts the whole count
//   0x57  self_test_error_tally, read only
// Every other offset reads as zero; writes to it are dropped.
//
// Access port timing:
//   A read request is answered one cycle later with a one-cycle
//   strobe; the read data then stands until the next answer.
//   A write to the port select steers reads from the next cycle.
//   A write and a read in one cycle read the old port selection.
//
// Hazards for software:
//   Read the high count byte first. The low byte read restarts the
//   count, so the other order loses the upper bits.
//   Keep the error source quiet between the two byte reads, or the
//   two halves may come from different counts.
//   The count saturates at all ones and never wraps to a small value.
`timescale 1ns/1ps
`default_nettype none
module rxs_status_regs
	import rxs_pkg::*;
#(
	parameter int NPORTS = RXS_NPORTS   // Receive ports
)
(
	// Clock and reset
	input  wire logic                CLOCK,
	input  wire logic                SRST,
	// Register access port from the I2C target
	input  wire logic [7:0]          REG_ADDR,
	input  wire logic                REG_RD,
	input  wire logic                REG_WR,
	input  wire logic [7:0]          REG_WDATA,
	output logic      [7:0]          REG_RDATA,
	output logic                     REG_RVALID,
	// Forward channel status, one byte lane per port
	input  wire logic [NPORTS-1:0]   FC_LOAD2,
	input  wire logic [NPORTS-1:0]   FC_LOAD3,
	input  wire logic [8*NPORTS-1:0] FC_DATA,
	// Link receiver events per port
	input  wire logic [NPORTS-1:0]   PAR_ERR,
	input  wire logic [NPORTS-1:0]   RX_LOCK,
	// Self-test events per port
	input  wire logic [NPORTS-1:0]   BIST_START,
	input  wire logic [NPORTS-1:0]   BIST_ERR
);
	// ************************************************************
	// Declarations
	// ************************************************************
	logic [7:0]            psel_r, psel_nxt;     // Port-select register
	logic [7:0]            rdata_r, rdata_nxt;   // Read data held for host
	logic                  rvalid_r, rvalid_nxt; // Read answer strobe
	logic [RXS_PSEL_W-1:0] port;                 // Port targeted now
	logic [7:0]            sts2_a [NPORTS];      // Gathered bank outputs
	logic [7:0]            sts3_a [NPORTS];
	logic [15:0]           cnt_a  [NPORTS];
	logic [7:0]            bist_a [NPORTS];
	logic [15:0]           sel_cnt;              // Count of targeted port
	logic [7:0]            sel_sts2;             // Status two of targeted port
	logic [7:0]            sel_sts3;             // Status three of targeted port
	logic [7:0]            sel_bist;             // Tally of targeted port

	rxs_bank_if bif [NPORTS] ();

	// Only the low bits pick the port; the rest are plain storage
	// that reads back, so software may keep tags in them
	assign port    = psel_r[RXS_PSEL_LSB +: RXS_PSEL_W];
	assign sel_cnt = cnt_a[port];
	assign sel_sts2 = sts2_a[port];
	assign sel_sts3 = sts3_a[port];
	assign sel_bist = bist_a[port];

	// ************************************************************
	// Per-port banks
	// ************************************************************
	// One bank per port; only the selected one sees a low-byte read
	for (genvar i = 0; i < NPORTS; i++)
	begin : g_port
		assign bif[i].rd_lo = REG_RD && (REG_ADDR == RXS_ADDR_PLO)
			&& (port == RXS_PSEL_W'(i));
		assign sts2_a[i] = bif[i].sts2;
		assign sts3_a[i] = bif[i].sts3;
		assign cnt_a[i]  = bif[i].cnt;
		assign bist_a[i] = bif[i].bist;

		rxs_port_bank u_bank (
			.clk        (CLOCK),
			.srst       (SRST),
			.fc_load2   (FC_LOAD2[i]),
			.fc_load3   (FC_LOAD3[i]),
			.fc_data    (FC_DATA[8*i +: 8]),
			.par_err    (PAR_ERR[i]),
			.lock       (RX_LOCK[i]),
			.bist_start (BIST_START[i]),
			.bist_err   (BIST_ERR[i]),
			.bus        (bif[i].bank)
		);
	end

	// ************************************************************
	// Register access
	// ************************************************************
	// Decode; writes to read-only bytes are dropped silently
	always_comb
	begin
		psel_nxt   = psel_r;
		rdata_nxt  = rdata_r;
		// Every read is answered by a strobe exactly one cycle later
		rvalid_nxt = REG_RD;
		if (REG_WR && (REG_ADDR == RXS_ADDR_PSEL))
			psel_nxt = REG_WDATA;
		// Read data is registered, so it stands until the next answer
		if (REG_RD)
		begin
			unique case (REG_ADDR)
				RXS_ADDR_PSEL: rdata_nxt = psel_r;
				RXS_ADDR_STS2: rdata_nxt = sts2_a[port];
				RXS_ADDR_STS3: rdata_nxt = sts3_a[port];
				RXS_ADDR_PHI:  rdata_nxt = sel_cnt[RXS_CNT_HI_LSB +: 8];
				// Pre-clear value is returned; clear lands the same edge
				RXS_ADDR_PLO:  rdata_nxt = sel_cnt[7:0];
				RXS_ADDR_BIST: rdata_nxt = bist_a[port];
				default:       rdata_nxt = RXS_RST_BYTE;          // Unmapped reads zero
			endcase
		end
	end

	// Registers only
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
		begin
			psel_r   <= RXS_RST_BYTE;
			rdata_r  <= RXS_RST_BYTE;
			rvalid_r <= 1'b0;
		end
		else
		begin
			psel_r   <= psel_nxt;
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	assign REG_RDATA  = rdata_r;
	assign REG_RVALID = rvalid_r;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SRST);

	// Reset leaves the answer port quiet and port zero selected
	a_reset_clear: assert property (@(posedge CLOCK) disable iff (1'b0)
		SRST |=> !REG_RVALID && REG_RDATA == RXS_RST_BYTE && psel_r == RXS_RST_BYTE)
		else $error("reset did not clear the access port");

	// Answer strobe: exactly one cycle per read, none without one
	a_read_answer: assert property (REG_RD |=> REG_RVALID)
		else $error("read not answered next cycle");
	a_rvalid_pulse: assert property (!REG_RD |=> !REG_RVALID)
		else $error("answer strobe without a read");
	a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
		else $error("read data moved without a read");

	// Port select takes a write at once and holds otherwise
	a_psel_write: assert property (REG_WR && REG_ADDR == RXS_ADDR_PSEL
		|=> psel_r == $past(REG_WDATA))
		else $error("port select write lost");
	a_psel_keep: assert property (!(REG_WR && REG_ADDR == RXS_ADDR_PSEL)
		|=> $stable(psel_r))
		else $error("port select changed without a write");

	// Each per-port byte comes from the port selected at the request
	a_sts2_route: assert property (REG_RD && REG_ADDR == RXS_ADDR_STS2
		|=> REG_RDATA == $past(sel_sts2))
		else $error("status two read from the wrong port");
	a_sts3_route: assert property (REG_RD && REG_ADDR == RXS_ADDR_STS3
		|=> REG_RDATA == $past(sel_sts3))
		else $error("status three read from the wrong port");
	a_bist_route: assert property (REG_RD && REG_ADDR == RXS_ADDR_BIST
		|=> REG_RDATA == $past(sel_bist))
		else $error("self-test tally read from the wrong port");
	a_unmapped_zero: assert property (REG_RD && REG_ADDR != RXS_ADDR_PSEL
		&& (REG_ADDR < RXS_ADDR_STS2 || REG_ADDR > RXS_ADDR_BIST)
		|=> REG_RDATA == RXS_RST_BYTE)
		else $error("unmapped read returned data");

	// Count bytes: high and low halves of the selected count
	a_hi_byte: assert property (REG_RD && REG_ADDR == RXS_ADDR_PHI
		|=> REG_RDATA == $past(sel_cnt) >> 8)
		else $error("high byte does not match count");
	a_lo_byte: assert property (REG_RD && REG_ADDR == RXS_ADDR_PLO
		|=> REG_RDATA == $past(sel_cnt) % 256)
		else $error("low byte does not match count");
	// A high byte read leaves the count; a low byte read restarts it
	a_hi_no_clear: assert property (REG_RD && REG_ADDR == RXS_ADDR_PHI
		&& $stable(psel_r) && !PAR_ERR[port] && !(RX_LOCK[port])
		|=> sel_cnt == $past(sel_cnt))
		else $error("high byte read changed count");
	a_lo_clears: assert property (REG_RD && REG_ADDR == RXS_ADDR_PLO && !REG_WR
		&& !PAR_ERR[port] |=> sel_cnt == RXS_RST_CNT)
		else $error("low byte read did not restart count");

endmodule : rxs_status_regs
`default_nettype wire

// File: common/rxs_pkg.sv
// Package for the receive-port status and error-count register bank.
// Assumes a byte-wide register access port behind the local I2C target.
package rxs_pkg;

	// ************************************************************
	// Sizing
	// ************************************************************
	localparam int          RXS_NPORTS     = 4;       // Receive ports in the hub
	localparam int          RXS_PSEL_W     = 2;       // Bits of read port index

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0]  RXS_ADDR_PSEL  = 8'h4c;   // Port-select register
	localparam logic [7:0]  RXS_ADDR_STS2  = 8'h53;   // sensor_status_word_two
	localparam logic [7:0]  RXS_ADDR_STS3  = 8'h54;   // sensor_status_word_three
	localparam logic [7:0]  RXS_ADDR_PHI   = 8'h55;   // parity_error_count_high
	localparam logic [7:0]  RXS_ADDR_PLO   = 8'h56;   // parity_error_count_low
	localparam logic [7:0]  RXS_ADDR_BIST  = 8'h57;   // self_test_error_tally

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int          RXS_PSEL_LSB   = 0;       // Read port index field
	localparam int          RXS_CNT_HI_LSB = 8;       // Upper byte of count
	localparam logic [7:0]  RXS_RST_BYTE   = 8'h00;   // Reset of every byte
	localparam logic [15:0] RXS_RST_CNT    = 16'h0000;
	localparam logic [15:0] RXS_CNT_MAX    = 16'hffff; // Saturation point
	localparam logic [7:0]  RXS_BIST_MAX   = 8'hff;    // Tally saturation

endpackage : rxs_pkg

// File: common/rxs_bank_if.sv
// Interface between the register hub and one per-port status bank.
// Assumes both ends sit on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface rxs_bank_if;
	logic        rd_lo;   // Host read of the low count byte, one cycle
	logic [7:0]  sts2;    // Forward-channel status word two
	logic [7:0]  sts3;    // Forward-channel status word three
	logic [15:0] cnt;     // Parity error count
	logic [7:0]  bist;    // Self-test error tally

	modport hub  (output rd_lo, input sts2, input sts3, input cnt, input bist);
	modport bank (input rd_lo, output sts2, output sts3, output cnt, output bist);
endinterface : rxs_bank_if
`default_nettype wire

// File: verilog/rxs_port_bank.sv
// One receive port's status words, parity count and self-test tally.
// Assumes all link-side inputs are synchronous one-cycle events or levels.
`timescale 1ns/1ps
`default_nettype none
module rxs_port_bank
	import rxs_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// Forward channel status loads
	input  wire logic       fc_load2,
	input  wire logic       fc_load3,
	input  wire logic [7:0] fc_data,
	// Link receiver events
	input  wire logic       par_err,
	input  wire logic       lock,
	// Self-test events
	input  wire logic       bist_start,
	input  wire logic       bist_err,
	// Register hub side
	rxs_bank_if.bank        bus
);
	// ************************************************************
	// State
	// ************************************************************
	logic [7:0]  sts2_r, sts2_nxt;   // Status word two
	logic [7:0]  sts3_r, sts3_nxt;   // Status word three
	logic [15:0] cnt_r, cnt_nxt;     // Parity error count
	logic [7:0]  bist_r, bist_nxt;   // Self-test tally
	logic        lock_r, lock_nxt;   // Lock seen last cycle
	logic        lock_rise;          // Lock newly gained
	logic        cnt_clr;            // Count restarts this cycle
	logic [15:0] cnt_base;           // Count after any restart

	// Next values
	always_comb
	begin
		lock_nxt  = lock;
		lock_rise = lock & ~lock_r;
		cnt_clr   = bus.rd_lo | lock_rise;
		cnt_base  = cnt_clr ? RXS_RST_CNT : cnt_r;
		// An error in the clearing cycle is kept: set wins over clear
		if (par_err && (cnt_base != RXS_CNT_MAX))
			cnt_nxt = cnt_base + 16'h0001;
		else
			cnt_nxt = cnt_base;
		sts2_nxt = fc_load2 ? fc_data : sts2_r;
		sts3_nxt = fc_load3 ? fc_data : sts3_r;
		// Tally saturates so a long test never looks clean
		if (bist_start)
			bist_nxt = RXS_RST_BYTE;
		else if (bist_err && (bist_r != RXS_BIST_MAX))
			bist_nxt = bist_r + 8'h01;
		else
			bist_nxt = bist_r;
	end

	// Registers only
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sts2_r <= RXS_RST_BYTE;
			sts3_r <= RXS_RST_BYTE;
			cnt_r  <= RXS_RST_CNT;
			bist_r <= RXS_RST_BYTE;
			lock_r <= 1'b0;
		end
		else
		begin
			sts2_r <= sts2_nxt;
			sts3_r <= sts3_nxt;
			cnt_r  <= cnt_nxt;
			bist_r <= bist_nxt;
			lock_r <= lock_nxt;
		end
	end

	assign bus.sts2 = sts2_r;
	assign bus.sts3 = sts3_r;
	assign bus.cnt  = cnt_r;
	assign bus.bist = bist_r;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_sts2_load: assert property (fc_load2 |=> sts2_r == $past(fc_data))
		else $error("status two not loaded");
	a_sts3_hold: assert property (!fc_load3 |=> $stable(sts3_r))
		else $error("status three changed without load");
	a_cnt_incr: assert property (!cnt_clr && par_err && cnt_r != RXS_CNT_MAX
		|=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("parity count missed an error");
	a_lock_restart: assert property (lock && !lock_r |=> cnt_r <= 16'h0001)
		else $error("count not restarted on lock");
	a_lo_clear: assert property (bus.rd_lo && !par_err |=> cnt_r == RXS_RST_CNT)
		else $error("low byte read did not clear count");
	a_cnt_saturate: assert property (cnt_r == RXS_CNT_MAX && !cnt_clr
		|=> cnt_r == RXS_CNT_MAX)
		else $error("parity count wrapped");
	a_bist_start: assert property (bist_start |=> bist_r == RXS_RST_BYTE ##1
		bist_r <= 8'h01)
		else $error("self-test tally not restarted");

endmodule : rxs_port_bank
`default_nettype wire

// File: bench/rxs_far_model.sv
// Far side of the hub: forward channel, link receiver, self-test events.
// Assumes the hub core clock; every change lands just after its rising edge.
`timescale 1ns/1ps
`default_nettype none
module rxs_far_model
	import rxs_pkg::*;
(
	// Clock
	input  wire logic                   clk,
	// Forward channel and link events
	output logic [RXS_NPORTS-1:0]       fc_load2,
	output logic [RXS_NPORTS-1:0]       fc_load3,
	output logic [8*RXS_NPORTS-1:0]     fc_data,
	output logic [RXS_NPORTS-1:0]       par_err,
	output logic [RXS_NPORTS-1:0]       rx_lock,
	// Self-test events
	output logic [RXS_NPORTS-1:0]       bist_start,
	output logic [RXS_NPORTS-1:0]       bist_err
);
	// ************************************************************
	// Idle levels; data lanes start scrambled, not stale
	// ************************************************************
	initial
	begin
		{fc_load2, fc_load3, par_err, rx_lock, bist_start, bist_err} = '0;
		fc_data = 32'h5a3c_96e1;
	end
	// One status byte; lane inverted after so no stale value lingers
	task automatic fc_send(input int p, input logic w3, input logic [7:0] d);
		@(posedge clk);
		fc_data[8*p +: 8] <= d;
		if (w3)
			fc_load3[p] <= 1'b1;
		else
			fc_load2[p] <= 1'b1;
		@(posedge clk);
		fc_load2[p] <= 1'b0;
		fc_load3[p] <= 1'b0;
		fc_data[8*p +: 8] <= ~d;
	endtask
	// Error level held n cycles counts n errors
	task automatic errs(input int p, input int n);
		repeat (n) @(posedge clk) par_err[p] <= 1'b1;
		@(posedge clk);
		par_err[p] <= 1'b0;
	endtask
	// Drop and regain receiver lock
	task automatic relock(input int p);
		@(posedge clk);
		rx_lock[p] <= 1'b0;
		@(posedge clk);
		rx_lock[p] <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	// Self-test run with n errors
	task automatic bist(input int p, input int n);
		@(posedge clk);
		bist_start[p] <= 1'b1;
		@(posedge clk);
		bist_start[p] <= 1'b0;
		repeat (n) @(posedge clk) bist_err[p] <= 1'b1;
		@(posedge clk);
		bist_err[p] <= 1'b0;
	endtask
endmodule // rxs_far_model
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the receive-port status register hub.
// Assumes the far-side model supplies every link and self-test event.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_count++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module tb;
	import rxs_pkg::*;
	logic        CLOCK = 1'b0;      // 40 MHz core clock
	logic        SRST = 1'b1;       // Held for three edges
	logic [7:0]  REG_ADDR = 8'h00;  // Register access port
	logic        REG_RD = 1'b0;
	logic        REG_WR = 1'b0;
	logic [7:0]  REG_WDATA = 8'h00;
	logic [7:0]  REG_RDATA;
	logic        REG_RVALID;
	logic [3:0]  ld2, ld3, perr, lock, bst, berr;
	logic [31:0] fcd;
	int          err_count = 0;     // Mismatches
	int          checked = 0;       // Comparisons
	always #12.5 CLOCK = ~CLOCK;
	rxs_status_regs #(.NPORTS(4)) i_rxs_status_regs (.CLOCK(CLOCK), .SRST(SRST),
		.REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
		.REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .FC_LOAD2(ld2), .FC_LOAD3(ld3),
		.FC_DATA(fcd), .PAR_ERR(perr), .RX_LOCK(lock), .BIST_START(bst), .BIST_ERR(berr));
	rxs_far_model i_rxs_far_model (.clk(CLOCK), .fc_load2(ld2), .fc_load3(ld3),
		.fc_data(fcd), .par_err(perr), .rx_lock(lock), .bist_start(bst), .bist_err(berr));
	// ************************************************************
	// Closing report, also reached when a wait runs out
	// ************************************************************
	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// One write pulse
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLOCK);
		REG_WR <= 1'b0;
	endtask
	// One read pulse, bounded wait for the answer strobe, then compare
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		int k;
		@(posedge CLOCK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLOCK);
		REG_RD <= 1'b0;
		#1;
		for (k = 0; k < 4 && REG_RVALID !== 1'b1; k++)
			@(posedge CLOCK) #1;
		if (k == 4)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t read answer missing", $time);
			end_of_test();
		end
		else
		begin
			`CHK(REG_RDATA, exp)
			// Strobe lasts one cycle; the data must still stand after it
			@(posedge CLOCK) #1;
			`CHK(REG_RVALID, 1'b0)
			`CHK(REG_RDATA, exp)
		end
	endtask
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		repeat (3) @(posedge CLOCK);
		SRST <= 1'b0;
		for (int a = 8'h53; a <= 8'h57; a++)
			rd(8'(a), RXS_RST_BYTE);
		rd(8'h60, 8'h00);
		$display("Test reset values done");
		// Distinct status per port, read back in reverse port order
		for (int p = 0; p < 4; p++)
		begin
			i_rxs_far_model.fc_send(p, 1'b0, 8'h50 + 8'(p));
			i_rxs_far_model.fc_send(p, 1'b1, 8'ha0 + 8'(p));
		end
		for (int p = 3; p >= 0; p--)
		begin
			wr(RXS_ADDR_PSEL, 8'(p));
			rd(RXS_ADDR_STS2, 8'h50 + 8'(p));
			rd(RXS_ADDR_STS3, 8'ha0 + 8'(p));
		end
		wr(RXS_ADDR_STS2, 8'h77);
		rd(RXS_ADDR_STS2, 8'h50);
		$display("Test status words done");
		// Error stream idle across both byte reads
		i_rxs_far_model.errs(1, 300);
		i_rxs_far_model.errs(2, 3);
		wr(RXS_ADDR_PSEL, 8'h01);
		rd(RXS_ADDR_PHI, 8'h01);
		rd(RXS_ADDR_PHI, 8'h01);
		rd(RXS_ADDR_PLO, 8'h2c);
		rd(RXS_ADDR_PHI, 8'h00);
		rd(RXS_ADDR_PLO, 8'h00);
		wr(RXS_ADDR_PSEL, 8'h02);
		rd(RXS_ADDR_PLO, 8'h03);
		i_rxs_far_model.errs(2, 5);
		i_rxs_far_model.relock(2);
		rd(RXS_ADDR_PLO, 8'h00);
		i_rxs_far_model.errs(2, 2);
		rd(RXS_ADDR_PLO, 8'h02);
		$display("Test parity count done");
		// Self-test tally and its restart
		i_rxs_far_model.bist(3, 4);
		wr(RXS_ADDR_PSEL, 8'h03);
		rd(RXS_ADDR_BIST, 8'h04);
		i_rxs_far_model.bist(3, 0);
		rd(RXS_ADDR_BIST, 8'h00);
		$display("Test self-test tally done");
		// Count held past its top value must stick at all ones
		i_rxs_far_model.errs(0, 65540);
		wr(RXS_ADDR_PSEL, 8'h00);
		rd(RXS_ADDR_PHI, 8'hff);
		rd(RXS_ADDR_PLO, 8'hff);
		$display("Test saturation done");
		// Mid-run reset: count, status and port select all restart
		i_rxs_far_model.errs(0, 3);
		wr(RXS_ADDR_PSEL, 8'h03);
		@(posedge CLOCK);
		SRST <= 1'b1;
		repeat (3) @(posedge CLOCK);
		SRST <= 1'b0;
		#1;
		`CHK(REG_RVALID, 1'b0)
		`CHK(REG_RDATA, RXS_RST_BYTE)
		rd(RXS_ADDR_PSEL, RXS_RST_BYTE);
		rd(RXS_ADDR_STS2, RXS_RST_BYTE);
		rd(RXS_ADDR_PLO, RXS_RST_BYTE);
		$display("Test mid-run reset done");
		end_of_test();
	end
endmodule // tb
`default_nettype wire
